// *** core/pimask_top.sv ***
// Interrupt mask low half, status latch, configuration bit and interrupt output.
//
// Summary of operation
// [RL1] Mask bit 11 enables interrupt on disconnect counter top bit rising.
// [RL2] Mask bit 10 enables interrupt on false carrier counter top bit rising.
// [RL3] Mask bit 9 enables interrupt on receive error counter top bit rising.
// [RL4] Mask bit 8 enables interrupt on elastic buffer fault during remote loopback.
// [RL5] Mask bit 7 resets to one; enables interrupt when reset and calibration done.
// [RL6] Mask bit 6 enables interrupt on 10 Mb/s jabber.
// [RL7] Mask bit 5 enables interrupt on link negotiation complete.
// [RL8] Mask bit 4 enables interrupt on unstable legacy signalling found.
// [RL9] Mask bit 3 enables interrupt on parallel detect of unadvertised technology.
// [RL10] Mask bit 2 enables interrupt on remote fault from negotiation or far-end detect.
// [RL11] Mask bit 1 enables interrupt on every received page.
// [RL12] Compatibility mode disables all mask bits and discards writes to them.
// [RL13] Clear mask bit keeps pin quiet but status still records the event.
// [RL14] Status bits clear when software reads the status register.
// [RL15] Interrupt held while any pending status bit is enabled; bit 0 reads zero.
`timescale 1ns/100ps
`default_nettype none
module pimask_top
  import pimask_pkg::*;
#(
  parameter int CNT_W = PIM_CNT_W
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [PIM_AW-1:0] reg_addr,
  input  wire logic [PIM_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [PIM_DW-1:0] reg_rdata,
  // Event sources
  input  wire logic [CNT_W-1:0]  disconnect_event_counter,
  input  wire logic [CNT_W-1:0]  false_carrier_event_counter,
  input  wire logic [CNT_W-1:0]  receive_error_event_counter,
  input  wire pimask_evt_t       evt,
  input  wire logic [3:0]        upper_evt,
  // Interrupt and mode outputs
  output logic                   irq,
  output logic                   compat_mode
);
  pimask_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [11:0]       mask_reg;
  logic [11:0]       mask_next;
  logic [3:0]        upmask_reg;
  logic [3:0]        upmask_next;
  logic [15:0]       stat_reg;
  logic [15:0]       stat_next;
  logic              compat_reg;
  logic              compat_next;
  logic              irq_reg;
  logic              irq_next;
  logic [PIM_DW-1:0] rdata_reg;
  logic [PIM_DW-1:0] rdata_next;
  logic              rst_seen_reg;
  logic              cal_seen_reg;
  logic              rst_ev_reg;

  logic        dcr_rise;
  logic        fcc_rise;
  logic        rec_rise;
  logic [15:0] ev_vec;
  logic [15:0] eff_mask;
  logic        sel_mask;
  logic        sel_stat;
  logic        sel_cfg;
  logic        sel_up;
  logic        rst_both;

  pimask_msb_rise #(.W(CNT_W)) u_dcr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cnt     (disconnect_event_counter),
    .rise    (dcr_rise)
  );
  pimask_msb_rise #(.W(CNT_W)) u_fcc (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cnt     (false_carrier_event_counter),
    .rise    (fcc_rise)
  );
  pimask_msb_rise #(.W(CNT_W)) u_rec (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cnt     (receive_error_event_counter),
    .rise    (rec_rise)
  );

  assign sel_mask = (bus.addr == PIM_OFF_MASK);
  assign sel_stat = (bus.addr == PIM_OFF_STATUS);
  assign sel_cfg  = (bus.addr == PIM_OFF_CONFIG);
  assign sel_up   = (bus.addr == PIM_OFF_UPPER);

  // Reset-complete fires once, when both the reset and calibration have been seen.
  assign rst_both = (rst_seen_reg | evt.reset_done) & (cal_seen_reg | evt.calib_done); // RL5

  // Event vector in mask layout.
  always_comb begin
    ev_vec            = '0;
    ev_vec[15:12]     = upper_evt;
    ev_vec[PIM_B_DCR] = dcr_rise; // RL1
    ev_vec[PIM_B_FCC] = fcc_rise; // RL2
    ev_vec[PIM_B_REC] = rec_rise; // RL3
    ev_vec[PIM_B_RLB] = evt.elastic_err & evt.rloop_fault; // RL4
    ev_vec[PIM_B_RST] = rst_both & ~rst_ev_reg; // RL5
    ev_vec[PIM_B_JAB] = evt.jabber; // RL6
    ev_vec[PIM_B_ANC] = evt.aneg_done; // RL7
    ev_vec[PIM_B_PDF] = evt.pdet_fault; // RL8
    ev_vec[PIM_B_PFL] = evt.pdet_fail; // RL9
    ev_vec[PIM_B_RMF] = evt.aneg_rfault | evt.fefi_rfault; // RL10
    ev_vec[PIM_B_PGR] = evt.page_rx; // RL11
  end

  // All enables act as inactive while compatibility mode is on; mask reads still return the stored bits.
  assign eff_mask = compat_reg ? 16'h0000 : {upmask_reg, mask_reg}; // RL12

  // Writes to the mask are dropped in compatibility mode; bit 0 never stores.
  assign mask_next = (bus.wr && sel_mask && !compat_reg) ? (bus.wdata[11:0] & PIM_LOW_WMASK) : mask_reg; // RL12 RL15
  assign upmask_next = (bus.wr && sel_mask && !compat_reg) ? bus.wdata[15:12] : upmask_reg; // RL12
  assign compat_next = (bus.wr && sel_cfg) ? bus.wdata[PIM_B_COMPAT] : compat_reg;

  // A read clears the status, but events landing in that cycle survive.
  assign stat_next = ((bus.rd && sel_stat) ? 16'h0000 : stat_reg) | (ev_vec & 16'hFFFE); // RL13 RL14

  assign irq_next = |(stat_next & eff_mask); // RL13 RL15

  always_comb begin
    rdata_next = '0;
    if (bus.rd) begin
      if (sel_mask) begin
        rdata_next = {upmask_reg, mask_reg}; // RL15
      end else if (sel_stat) begin
        rdata_next = stat_reg;
      end else if (sel_cfg) begin
        rdata_next[PIM_B_COMPAT] = compat_reg;
      end else if (sel_up) begin
        rdata_next[3:0] = upper_evt;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg   <= PIM_LOW_RESET; // RL5
      upmask_reg <= PIM_UP_RESET;
      compat_reg <= 1'b0;
      stat_reg   <= '0;
      irq_reg    <= 1'b0;
      rdata_reg  <= '0;
    end else begin
      mask_reg   <= mask_next;
      upmask_reg <= upmask_next;
      compat_reg <= compat_next;
      stat_reg   <= stat_next;
      irq_reg    <= irq_next;
      rdata_reg  <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_seen_reg <= 1'b0;
      cal_seen_reg <= 1'b0;
      rst_ev_reg   <= 1'b0;
    end else begin
      rst_seen_reg <= rst_seen_reg | evt.reset_done;
      cal_seen_reg <= cal_seen_reg | evt.calib_done;
      rst_ev_reg   <= rst_ev_reg | rst_both;
    end
  end

  assign reg_rdata   = rdata_reg;
  assign irq         = irq_reg;
  assign compat_mode = compat_reg;
endmodule : pimask_top
`default_nettype wire

// *** core/pimask_pkg.sv ***
// Package with register map, field positions and carrier types for the interrupt mask block.
package pimask_pkg;
  localparam int          PIM_DW           = 16;
  localparam int          PIM_AW           = 5;
  localparam int          PIM_CNT_W        = 16;
  localparam logic [4:0]  PIM_OFF_MASK     = 5'h10;
  localparam logic [4:0]  PIM_OFF_STATUS   = 5'h11;
  localparam logic [4:0]  PIM_OFF_CONFIG   = 5'h1C;
  localparam logic [4:0]  PIM_OFF_UPPER    = 5'h1D;
  localparam int          PIM_B_DCR        = 11;
  localparam int          PIM_B_FCC        = 10;
  localparam int          PIM_B_REC        = 9;
  localparam int          PIM_B_RLB        = 8;
  localparam int          PIM_B_RST        = 7;
  localparam int          PIM_B_JAB        = 6;
  localparam int          PIM_B_ANC        = 5;
  localparam int          PIM_B_PDF        = 4;
  localparam int          PIM_B_PFL        = 3;
  localparam int          PIM_B_RMF        = 2;
  localparam int          PIM_B_PGR        = 1;
  localparam int          PIM_B_COMPAT     = 0;
  localparam logic [11:0] PIM_LOW_RESET    = 12'h080;
  localparam logic [11:0] PIM_LOW_WMASK    = 12'hFFE;
  localparam logic [3:0]  PIM_UP_RESET     = 4'h4;

  // Event pulses from the transceiver logic, one cycle each.
  typedef struct packed {
    logic rloop_fault;
    logic elastic_err;
    logic reset_done;
    logic calib_done;
    logic jabber;
    logic aneg_done;
    logic pdet_fault;
    logic pdet_fail;
    logic aneg_rfault;
    logic fefi_rfault;
    logic page_rx;
  } pimask_evt_t;

  // Register port carrier.
  typedef struct packed {
    logic [PIM_AW-1:0] addr;
    logic [PIM_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } pimask_bus_t;
endpackage : pimask_pkg

// *** core/pimask_msb_rise.sv ***
// Rising-edge detector on the top bit of an event counter.
`timescale 1ns/100ps
`default_nettype none
module pimask_msb_rise
  import pimask_pkg::*;
#(
  parameter int W = PIM_CNT_W
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Counter value
  input  wire logic [W-1:0] cnt,
  // One-cycle pulse on 0 to 1 of the top bit
  output logic              rise
);
  logic msb_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      msb_reg <= 1'b0;
    end else begin
      msb_reg <= cnt[W-1];
    end
  end
  assign rise = cnt[W-1] & ~msb_reg;
endmodule : pimask_msb_rise
`default_nettype wire

// *** tb/pimask_top_props.sv ***
// Checker for the interrupt mask block.
`timescale 1ns/100ps
`default_nettype none
module pimask_top_props
  import pimask_pkg::*;
#(
  parameter int CNT_W = PIM_CNT_W
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [PIM_AW-1:0] reg_addr,
  input wire logic [PIM_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [PIM_DW-1:0] reg_rdata,
  // Event sources
  input wire logic [CNT_W-1:0]  disconnect_event_counter,
  input wire logic [CNT_W-1:0]  false_carrier_event_counter,
  input wire logic [CNT_W-1:0]  receive_error_event_counter,
  input wire pimask_evt_t       evt,
  input wire logic [3:0]        upper_evt,
  // Outputs
  input wire logic              irq,
  input wire logic              compat_mode
);
  logic [11:0] msk_reg;
  logic [2:0]  msb_reg;
  wire         rs = reg_rd && reg_addr == PIM_OFF_STATUS;
  wire         q = evt == '0 && upper_evt == 4'h0;
  wire [2:0]   msb = {disconnect_event_counter[CNT_W-1], false_carrier_event_counter[CNT_W-1],
                      receive_error_event_counter[CNT_W-1]};
  wire         cause = !q || reg_wr || msb != msb_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the stored low mask, to know which events may drive the interrupt.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      msk_reg <= PIM_LOW_RESET;
      msb_reg <= 3'h0;
    end else begin
      msb_reg <= msb;
      if (reg_wr && reg_addr == PIM_OFF_MASK && !compat_mode) msk_reg <= reg_wdata[11:0] & PIM_LOW_WMASK;
    end
  end
  sequence s_quiet; q && msb == msb_reg; endsequence
  sequence s_stat_rd; s_quiet ##1 rs && q && msb == msb_reg ##1 s_quiet; endsequence
  property p_cnt; |(msb & ~msb_reg & msk_reg[11:9]) && !compat_mode |=> ##[0:1] irq; endproperty
  property p_lbk; evt.elastic_err && evt.rloop_fault && msk_reg[8] && !compat_mode |=> irq; endproperty
  property p_evt; |({evt.jabber, evt.aneg_done, evt.pdet_fault, evt.pdet_fail, evt.aneg_rfault || evt.fefi_rfault,
    evt.page_rx} & msk_reg[6:1]) && !compat_mode |=> irq; endproperty
  property p_cmp; compat_mode [*2] |-> !irq; endproperty
  property p_quiet; $rose(irq) |-> $past(cause) || $past(cause, 2) || $past(cause, 3); endproperty
  property p_clr; s_stat_rd |=> !irq; endproperty
  property p_mrd; reg_rd && reg_addr == PIM_OFF_MASK |=> reg_rdata[11:0] == $past(msk_reg); endproperty
  property p_hold; irq && !rs && !$past(rs) && !reg_wr && !$past(reg_wr) && !compat_mode |=> irq; endproperty
  a_cnt: assert property (p_cnt) else $error("counter top bit did not raise irq");
  a_lbk: assert property (p_lbk) else $error("loopback fault did not raise irq");
  a_evt: assert property (p_evt) else $error("enabled event did not raise irq");
  a_cmp: assert property (p_cmp) else $error("irq high in compat mode");
  a_quiet: assert property (p_quiet) else $error("irq rose without cause");
  a_clr: assert property (p_clr) else $error("irq stayed after status read");
  a_mrd: assert property (p_mrd) else $error("mask readback wrong");
  a_hold: assert property (p_hold) else $error("irq dropped while pending");
endmodule : pimask_top_props
bind pimask_top pimask_top_props #(.CNT_W(CNT_W)) u_props (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .disconnect_event_counter(disconnect_event_counter), .false_carrier_event_counter(false_carrier_event_counter),
  .receive_error_event_counter(receive_error_event_counter), .evt(evt), .upper_evt(upper_evt), .irq(irq),
  .compat_mode(compat_mode));
`default_nettype wire

// *** tb/pimask_top_tb.sv ***
// Self-checking bench for the interrupt mask block.
`timescale 1ns/100ps
`default_nettype none
module pimask_top_tb
  import pimask_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [4:0]        reg_addr = '0;
  logic [15:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [15:0]       reg_rdata;
  logic [15:0]       dc = '0, fc = '0, rc = '0;
  pimask_evt_t       evt = '0;
  logic [3:0]        up = '0;
  logic              irq;
  logic              compat_mode;
  int                n_mismatch = 0;
  int                tests_run = 0;
  logic [13:0]       pat[11] = '{14'h2000, 14'h1000, 14'h0800, 14'h0600, 14'h0040, 14'h0020, 14'h0010, 14'h0008,
                                 14'h0004, 14'h0002, 14'h0001};
  int                bits[11] = '{11, 10, 9, 8, 6, 5, 4, 3, 2, 2, 1};
  pimask_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disconnect_event_counter(dc), .false_carrier_event_counter(fc),
    .receive_error_event_counter(rc), .evt(evt), .upper_evt(up), .irq(irq), .compat_mode(compat_mode));
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!w) chk(reg_rdata, d);
  endtask : acc
  task automatic fire(input logic [13:0] p);
    @(posedge sys_clk);
    {dc[15], fc[15], rc[15]} <= p[13:11];
    evt <= p[10:0];
    @(posedge sys_clk);
    evt <= '0;
  endtask : fire
  task automatic irq_is(input int n, input logic v);
    repeat (n) @(posedge sys_clk);
    #1 chk({15'h0, irq}, {15'h0, v});
  endtask : irq_is
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(0, PIM_OFF_MASK, 16'h4080);
    fire(14'h0100);
    fire(14'h0080);
    irq_is(3, 1);
    acc(0, PIM_OFF_STATUS, 16'h0080);
    for (int i = 0; i < 11; i++) begin
      acc(1, PIM_OFF_MASK, 16'h0001 << bits[i]);
      fire(pat[i]);
      irq_is(3, 1);
      acc(0, PIM_OFF_STATUS, 16'h0001 << bits[i]);
      irq_is(2, 0);
    end
    acc(1, PIM_OFF_MASK, 16'h0000);
    fire(14'h0040);
    irq_is(3, 0);
    acc(0, PIM_OFF_STATUS, 16'h0040);
    acc(1, PIM_OFF_MASK, 16'h0041);
    acc(0, PIM_OFF_MASK, 16'h0040);
    acc(1, PIM_OFF_CONFIG, 16'h0001);
    chk({15'h0, compat_mode}, 16'h0001);
    acc(1, PIM_OFF_MASK, 16'hFFFE);
    acc(0, PIM_OFF_MASK, 16'h0040);
    fire(14'h0040);
    irq_is(3, 0);
    acc(1, PIM_OFF_CONFIG, 16'h0000);
    irq_is(3, 1);
    acc(0, PIM_OFF_STATUS, 16'h0040);
    acc(0, 5'h03, 16'h0000);
    acc(1, PIM_OFF_MASK, 16'h4000);
    @(posedge sys_clk);
    up <= 4'h4;
    acc(0, PIM_OFF_UPPER, 16'h0004);
    @(posedge sys_clk);
    up <= 4'h0;
    irq_is(2, 1);
    acc(0, PIM_OFF_STATUS, 16'h4000);
    irq_is(2, 0);
    summarize();
  end
endmodule : pimask_top_tb
`default_nettype wire
